/* motor_pins_pkg.sv */
// shared types and constants for the motor control pin interface
package motor_pins_pkg;

  // ----------------------------------------
  // widths and counts
  // ----------------------------------------
  localparam int SPEED_W = 16;
  localparam int FILT_W = 8;
  localparam int WIN_W = 10;
  localparam int SYNC_STAGES = 2;
  localparam logic [WIN_W-1:0] WINDOW_LAST = 10'h3FF; // measurement window of 1024 cycles
  localparam logic [SPEED_W-1:0] SPEED_ZERO = 16'h0000;

  // ----------------------------------------
  // reference source select encodings
  // ----------------------------------------
  typedef logic [1:0] speed_mode_t;
  localparam speed_mode_t MODE_ANALOG = 2'h0;
  localparam speed_mode_t MODE_PWM = 2'h1;
  localparam speed_mode_t MODE_I2C = 2'h2;
  localparam speed_mode_t MODE_FREQ = 2'h3;

  // ----------------------------------------
  // phase selects, one-hot, bit 0 is phase a
  // ----------------------------------------
  localparam logic [2:0] PHASE_A = 3'h1;
  localparam logic [2:0] PHASE_B = 3'h2;
  localparam logic [2:0] PHASE_C = 3'h4;

  // ----------------------------------------
  // state machines
  // ----------------------------------------
  typedef enum logic [2:0] {
    BRK_RUN = 3'h1,
    BRK_RAMP = 3'h2,
    BRK_HOLD = 3'h4
  } brake_state_e;

  typedef enum logic [2:0] {
    DRV_ON = 3'h1,
    DRV_COAST = 3'h2,
    DRV_RESTART = 3'h4
  } drive_state_e;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic brake_ovr_en;
    logic brake_ovr_val;
    logic dir_ovr_en;
    logic dir_ovr_val;
    logic alarm_pin_en;
    logic pullup_nv;
    speed_mode_t speed_mode;
    logic [FILT_W-1:0] glitch_cycles;
    logic [SPEED_W-1:0] brake_speed_threshold;
    logic [SPEED_W-1:0] i2c_speed_cmd;
  } cfg_s;

  typedef struct packed {
    logic actionable;
    logic report_only;
  } fault_in_s;

  typedef struct packed {
    logic fault_low_o;
    logic fault_low_oe_n;
    logic alarm_o;
    logic alarm_oe_n;
  } fault_pins_s;

  typedef struct packed {
    logic braking;
    logic ramping;
    logic coasting;
    logic sleep_req;
    logic fwd;
  } status_s;

endpackage

/* speed_deglitch.sv */
// glitch filter for the digital speed input
`timescale 1ns/10ps

module speed_deglitch #(
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // filter control
  input wire logic enable,
  input wire logic [CNT_W-1:0] hold_cycles,
  // data
  input wire logic raw,
  output logic filtered
);

  logic [CNT_W-1:0] cnt_ff;
  logic out_ff;

  // count how long the input has differed from the output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (raw == out_ff || !enable) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // when enabled, accept a new level only once it has held longer than the setting; when disabled, follow the input
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_ff <= 1'b0;
    end else if (!enable || (raw != out_ff && cnt_ff >= hold_cycles)) begin
      out_ff <= raw;
    end
  end

  assign filtered = out_ff;

endmodule

/* motor_pin_if.sv */
// control and monitoring pin logic of the motor driver
//
// Notes on behaviour
// - on brake, limit speed to brake threshold first, then enter brake
// - stay in brake while the brake input stays high
// - brake override setting wins over the brake pin
// - direction high steps a,b,c; low steps a,c,b
// - direction override setting wins over the direction pin
// - driver disable high turns all six switches off, motor coasts
// - driver disable falling runs the restart sequence
// - driver disable never requests sleep; core keeps running
// - sleep follows only the speed input or the i2c speed command
// - speed input takes pwm duty, frequency or analog level
// - fault low output pulled low on a fault
// - alarm enabled: report-only faults raise alarm only
// - alarm enabled: actionable faults raise alarm and pull fault low
// - alarm disabled: alarm hi-z, every fault pulls fault low
// - speed pulse output toggles at a rate following motor speed
// - pull-up select takes effect only at power-up from stored value
// - pwm mode applies a configurable deglitch filter on speed input
// - host writes stored configuration and reads fault and motor state
// - reference select 00 analog, 01 pwm, 10 i2c, 11 frequency
`timescale 1ns/10ps

module motor_pin_if (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control pins
  input wire logic brake_pin,
  input wire logic dir_pin,
  input wire logic driver_disable_input,
  input wire logic speed_pin,
  // configuration from the serial port and stored memory
  input wire motor_pins_pkg::cfg_s cfg,
  // analog level from the converter
  input wire logic [motor_pins_pkg::SPEED_W-1:0] analog_speed_level,
  // motor core
  input wire logic [motor_pins_pkg::SPEED_W-1:0] motor_speed,
  input wire logic comm_step,
  input wire motor_pins_pkg::fault_in_s faults,
  output logic [motor_pins_pkg::SPEED_W-1:0] speed_ref,
  output logic [2:0] phase_sel,
  output logic gates_off,
  output logic restart_req,
  // monitor pins
  output motor_pins_pkg::fault_pins_s fault_pins,
  output logic speed_pulse_output,
  output logic pullup_active,
  // state for the serial port readback
  output motor_pins_pkg::status_s status
);
  import motor_pins_pkg::*;

  // ----------------------------------------
  // reset release and input synchronisers
  // ----------------------------------------
  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic [SYNC_STAGES-1:0] brake_sync_ff;
  logic [SYNC_STAGES-1:0] dir_sync_ff;
  logic [SYNC_STAGES-1:0] off_sync_ff;
  logic [SYNC_STAGES-1:0] spd_sync_ff;

  // reset is taken away cleanly on the clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      brake_sync_ff <= '0;
      dir_sync_ff <= '0;
      off_sync_ff <= '0;
      spd_sync_ff <= '0;
    end else begin
      brake_sync_ff <= {brake_sync_ff[0], brake_pin};
      dir_sync_ff <= {dir_sync_ff[0], dir_pin};
      off_sync_ff <= {off_sync_ff[0], driver_disable_input};
      spd_sync_ff <= {spd_sync_ff[0], speed_pin};
    end
  end

  // ----------------------------------------
  // effective brake and direction
  // ----------------------------------------
  logic brake_eff;
  logic fwd;
  // override setting wins over the pin
  assign brake_eff = cfg.brake_ovr_en ? cfg.brake_ovr_val : brake_sync_ff[1];
  // override setting wins over the pin
  assign fwd = cfg.dir_ovr_en ? cfg.dir_ovr_val : dir_sync_ff[1];

  // ----------------------------------------
  // speed input measurement
  // ----------------------------------------
  logic spd_filt;
  logic spd_prev_ff;
  logic [WIN_W-1:0] win_ff;
  logic [WIN_W:0] high_cnt_ff;
  logic [WIN_W:0] edge_cnt_ff;
  logic [SPEED_W-1:0] pwm_val_ff;
  logic [SPEED_W-1:0] freq_val_ff;
  logic [SPEED_W-1:0] sel_ref;
  logic win_end;

  // deglitch only in pwm mode; other modes pass straight through
  speed_deglitch #(.CNT_W(FILT_W)) u_deglitch (
    .clk(clk),
    .rst_n(rst_n),
    .enable(cfg.speed_mode == MODE_PWM),
    .hold_cycles(cfg.glitch_cycles),
    .raw(spd_sync_ff[1]),
    .filtered(spd_filt)
  );

  assign win_end = (win_ff == WINDOW_LAST);

  // fixed window trades response time for a simple divider-free measure
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      win_ff <= '0;
      spd_prev_ff <= 1'b0;
      high_cnt_ff <= '0;
      edge_cnt_ff <= '0;
    end else begin
      win_ff <= win_ff + 1'b1;
      spd_prev_ff <= spd_filt;
      if (win_end) begin
        high_cnt_ff <= {{WIN_W{1'b0}}, spd_filt}; // this sample opens the next window
        edge_cnt_ff <= {{WIN_W{1'b0}}, spd_filt & ~spd_prev_ff};
      end else begin
        high_cnt_ff <= high_cnt_ff + {{WIN_W{1'b0}}, spd_filt};
        edge_cnt_ff <= edge_cnt_ff + {{WIN_W{1'b0}}, spd_filt & ~spd_prev_ff};
      end
    end
  end

  // latch duty and edge count at each window end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_val_ff <= SPEED_ZERO;
      freq_val_ff <= SPEED_ZERO;
    end else if (win_end) begin
      pwm_val_ff <= SPEED_W'(high_cnt_ff);
      freq_val_ff <= SPEED_W'(edge_cnt_ff);
    end
  end

  // analog, pwm duty or frequency from the speed input, or the i2c speed command
  always_comb begin
    case (cfg.speed_mode)
      MODE_ANALOG: sel_ref = analog_speed_level;
      MODE_PWM: sel_ref = pwm_val_ff;
      MODE_I2C: sel_ref = cfg.i2c_speed_cmd;
      default: sel_ref = freq_val_ff;
    endcase
  end

  // ----------------------------------------
  // brake sequence
  // ----------------------------------------
  brake_state_e brk_ff;
  brake_state_e nxt_brk;

  always_comb begin
    nxt_brk = brk_ff;
    case (brk_ff)
      BRK_RUN: begin
        if (brake_eff) begin
          nxt_brk = BRK_RAMP;
        end
      end
      BRK_RAMP: begin
        if (!brake_eff) begin
          nxt_brk = BRK_RUN;
        end else if (motor_speed <= cfg.brake_speed_threshold) begin
          nxt_brk = BRK_HOLD;
        end
      end
      BRK_HOLD: begin
        if (!brake_eff) begin
          nxt_brk = BRK_RUN;
        end
      end
      default: nxt_brk = BRK_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      brk_ff <= BRK_RUN;
    end else begin
      brk_ff <= nxt_brk;
    end
  end

  // speed reference is clamped during the ramp and zero in brake
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      speed_ref <= SPEED_ZERO;
    end else if (nxt_brk == BRK_HOLD) begin
      speed_ref <= SPEED_ZERO;
    end else if (nxt_brk == BRK_RAMP && sel_ref > cfg.brake_speed_threshold) begin
      speed_ref <= cfg.brake_speed_threshold;
    end else begin
      speed_ref <= sel_ref;
    end
  end

  // ----------------------------------------
  // driver disable and restart
  // ----------------------------------------
  drive_state_e drv_ff;
  drive_state_e nxt_drv;
  logic off_now;
  assign off_now = off_sync_ff[1];

  always_comb begin
    nxt_drv = drv_ff;
    case (drv_ff)
      DRV_ON: begin
        if (off_now) begin
          nxt_drv = DRV_COAST;
        end
      end
      DRV_COAST: begin
        if (!off_now) begin
          nxt_drv = DRV_RESTART;
        end
      end
      DRV_RESTART: begin
        nxt_drv = off_now ? DRV_COAST : DRV_ON;
      end
      default: nxt_drv = DRV_ON;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drv_ff <= DRV_ON;
    end else begin
      drv_ff <= nxt_drv;
    end
  end

  assign gates_off = (drv_ff == DRV_COAST);
  assign restart_req = (drv_ff == DRV_RESTART);

  // ----------------------------------------
  // commutation order and speed pulses
  // ----------------------------------------
  // forward a,b,c; reverse a,c,b
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_sel <= PHASE_A;
    end else if (restart_req) begin
      phase_sel <= PHASE_A;
    end else if (comm_step && !gates_off) begin
      if (fwd) begin
        phase_sel <= {phase_sel[1:0], phase_sel[2]};
      end else begin
        phase_sel <= {phase_sel[0], phase_sel[2:1]};
      end
    end
  end

  // one edge per commutation step tracks motor speed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      speed_pulse_output <= 1'b0;
    end else if (comm_step && !gates_off) begin
      speed_pulse_output <= ~speed_pulse_output;
    end
  end

  // ----------------------------------------
  // pull-up select, caught once after reset
  // ----------------------------------------
  logic pu_taken_ff;
  // later writes to the stored bit wait for the next power-up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pu_taken_ff <= 1'b0;
      pullup_active <= 1'b0;
    end else if (!pu_taken_ff) begin
      pu_taken_ff <= 1'b1;
      pullup_active <= cfg.pullup_nv;
    end
  end

  // ----------------------------------------
  // fault pins
  // ----------------------------------------
  logic fault_pull;
  assign fault_pull = faults.actionable | (faults.report_only & ~cfg.alarm_pin_en);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_pins <= '{fault_low_o: 1'b0, fault_low_oe_n: 1'b1, alarm_o: 1'b0, alarm_oe_n: 1'b1};
    end else begin
      fault_pins.fault_low_o <= 1'b0;        // open drain: only ever pulls low
      fault_pins.fault_low_oe_n <= ~fault_pull;
      fault_pins.alarm_o <= faults.actionable | faults.report_only;
      fault_pins.alarm_oe_n <= ~cfg.alarm_pin_en; // disabled alarm floats
    end
  end

  // ----------------------------------------
  // status readback
  // ----------------------------------------
  // state visible to the serial port
  // sleep request depends only on the reference
  assign status = '{braking: brk_ff == BRK_HOLD, ramping: brk_ff == BRK_RAMP,
                    coasting: gates_off, sleep_req: sel_ref == SPEED_ZERO, fwd: fwd};

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_brake_after_ramp: assert property (
    $rose(status.braking) |-> $past(brk_ff) == BRK_RAMP && $past(motor_speed) <=
      $past(cfg.brake_speed_threshold)) else $error("brake entered without ramp");
  chk_brake_holds: assert property (
    status.braking && brake_eff |=> status.braking) else $error("brake left early");
  chk_brake_override: assert property (
    cfg.brake_ovr_en && !cfg.brake_ovr_val && brk_ff == BRK_RUN |=> brk_ff == BRK_RUN)
    else $error("override did not block brake");
  chk_dir_order: assert property (
    comm_step && !gates_off && !restart_req && fwd && phase_sel == PHASE_A |=>
      phase_sel == PHASE_B) else $error("forward order wrong");
  chk_dir_reverse: assert property (
    comm_step && !gates_off && !restart_req && !fwd && phase_sel == PHASE_A |=>
      phase_sel == PHASE_C) else $error("reverse order wrong");
  chk_coast_on_off: assert property (
    off_now && drv_ff == DRV_ON |=> gates_off) else $error("disable did not coast");
  chk_restart_seq: assert property (
    gates_off && !off_now |=> restart_req ##1 (!restart_req && phase_sel == PHASE_A)
      or gates_off) else $error("no restart after disable");
  chk_sleep_source: assert property (
    $changed(off_now) && $stable(sel_ref) |=> $stable(status.sleep_req))
    else $error("sleep followed driver disable");
  chk_report_only: assert property (
    cfg.alarm_pin_en && faults.report_only && !faults.actionable |=>
      fault_pins.fault_low_oe_n && fault_pins.alarm_o && !fault_pins.alarm_oe_n)
    else $error("report fault routed wrong");
  chk_actionable: assert property (
    faults.actionable |=> !fault_pins.fault_low_oe_n && fault_pins.alarm_o)
    else $error("actionable fault not shown");
  chk_alarm_off: assert property (
    !cfg.alarm_pin_en && faults.report_only |=>
      fault_pins.alarm_oe_n && !fault_pins.fault_low_oe_n) else $error("disabled alarm wrong");
  chk_pulse_step: assert property (
    comm_step && !gates_off |=> $changed(speed_pulse_output)) else $error("no speed pulse");
  chk_pullup_frozen: assert property (
    pu_taken_ff |=> $stable(pullup_active)) else $error("pull-up changed live");
  chk_i2c_ref: assert property (
    cfg.speed_mode == MODE_I2C && brk_ff == BRK_RUN && !brake_eff |=>
      speed_ref == $past(cfg.i2c_speed_cmd)) else $error("i2c reference not used");

  cov_brake: cover property (brk_ff == BRK_RAMP ##[1:50] brk_ff == BRK_HOLD);
  cov_restart: cover property (gates_off ##1 restart_req);
  cov_report: cover property (cfg.alarm_pin_en && faults.report_only);
  cov_reverse: cover property (comm_step && !fwd);

endmodule

/* host_model.sv */
// host controller model that drives the control pins and the configuration
`timescale 1ns/10ps

module host_model (
  // clock
  input wire logic clk,
  // pins and configuration toward the device
  output logic brake_pin,
  output logic dir_pin,
  output logic driver_disable_input,
  output logic speed_pin,
  output motor_pins_pkg::cfg_s cfg,
  // open-drain fault line seen by the host
  input wire motor_pins_pkg::fault_pins_s fault_pins,
  output logic fault_line
);
  import motor_pins_pkg::*;

  // quiet pins at time zero, before the first write
  initial begin
    {brake_pin, dir_pin, driver_disable_input, speed_pin} = 4'h0;
    cfg = '0;
  end

  // control pin writes
  // pin levels change just after an edge and then stand as levels
  task automatic put_pins(input logic [3:0] p);
    @(posedge clk);
    #1;
    {brake_pin, dir_pin, driver_disable_input, speed_pin} = p;
  endtask

  // stored config writes
  // the pull-up choice only lands at the next reset, so it is written like any field
  task automatic put_cfg(input cfg_s c);
    @(posedge clk);
    #1;
    cfg = c;
  endtask

  // board pull-up holds the line high whenever the device lets go
  assign fault_line = fault_pins.fault_low_oe_n ? 1'b1 : fault_pins.fault_low_o;
endmodule

/* testbench.sv */
// self-checking bench for the motor control pin logic
`timescale 1ns/10ps

module testbench;
  import motor_pins_pkg::*;

  logic clk;
  logic rstn;
  logic brake_pin, dir_pin, drv_off, speed_pin;
  cfg_s cfg;
  cfg_s c;
  logic [15:0] analog, mspeed, speed_ref;
  logic comm_step, gates_off, restart_req, speed_pulse, pullup_active, fault_line;
  logic fwd, exp_sp;
  logic [2:0] phase_sel, exp_ph;
  fault_in_s faults;
  fault_pins_s fpins;
  status_s status;
  int err_count = 0;
  int n_checks = 0;
  int k;
  // rows: alarm enable, actionable, report-only, fault oe_n, alarm oe_n, alarm level
  logic [5:0] rows [8] = '{6'h06, 6'h0A, 6'h12, 6'h1A, 6'h24, 6'h2D, 6'h31, 6'h39};

  host_model host (.clk(clk), .brake_pin(brake_pin), .dir_pin(dir_pin),
    .driver_disable_input(drv_off), .speed_pin(speed_pin), .cfg(cfg),
    .fault_pins(fpins), .fault_line(fault_line));

  motor_pin_if DUT (.clk(clk), .rstn(rstn), .brake_pin(brake_pin), .dir_pin(dir_pin),
    .driver_disable_input(drv_off), .speed_pin(speed_pin), .cfg(cfg),
    .analog_speed_level(analog), .motor_speed(mspeed), .comm_step(comm_step),
    .faults(faults), .speed_ref(speed_ref), .phase_sel(phase_sel), .gates_off(gates_off),
    .restart_req(restart_req), .fault_pins(fpins), .speed_pulse_output(speed_pulse),
    .pullup_active(pullup_active), .status(status));

  // 100 MHz core clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask

  // all stimulus lands 1 ns after a rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one-cycle commutation tick
  task automatic step;
    @(posedge clk);
    #1;
    comm_step = 1'b1;
    @(posedge clk);
    #1;
    comm_step = 1'b0;
  endtask

  task automatic do_reset;
    rstn = 1'b0;
    cyc(6);
    chk_word(speed_ref, 16'h0000);
    chk_word({13'h0000, phase_sel}, {13'h0000, PHASE_A});
    chk_bit(gates_off, 1'b0);
    chk_bit(fpins.fault_low_oe_n, 1'b1);
    chk_bit(fpins.alarm_oe_n, 1'b1);
    chk_bit(speed_pulse, 1'b0);
    rstn = 1'b1;
    cyc(4);
  endtask

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // whole run is about 9.3k cycles; this cuts a hang well after that
  initial begin
    #500000;
    err_count++;
    close_out;
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    comm_step = 1'b0;
    analog = 16'h0123;
    mspeed = 16'h2000;
    faults = '0;
    c = '0;
    c.speed_mode = MODE_I2C;
    c.i2c_speed_cmd = 16'h1000;
    c.brake_speed_threshold = 16'h0400;
    c.pullup_nv = 1'b1;
    c.glitch_cycles = 8'h02;
    host.put_cfg(c);
    do_reset;
    chk_bit(pullup_active, 1'b1);
    $display("test reset done");

    // fault pin table
    for (int i = 0; i < 8; i++) begin
      c.alarm_pin_en = rows[i][5];
      host.put_cfg(c);
      faults = {rows[i][4], rows[i][3]};
      cyc(3);
      chk_bit(fpins.fault_low_oe_n, rows[i][2]);
      chk_bit(fault_line, rows[i][2]);
      chk_bit(fpins.alarm_oe_n, rows[i][1]);
      if (rows[i][5]) chk_bit(fpins.alarm_o, rows[i][0]);
    end
    faults = '0;
    $display("test fault rows done");

    // direction: pin high, pin low, pin high overridden to reverse
    exp_ph = PHASE_A;
    exp_sp = 1'b0;
    for (int d = 0; d < 3; d++) begin
      fwd = (d == 0);
      c.dir_ovr_en = (d == 2);
      c.dir_ovr_val = 1'b0;
      host.put_cfg(c);
      host.put_pins({1'b0, d != 1, 2'h0});
      cyc(4);
      chk_bit(status.fwd, fwd);
      repeat (3) begin
        step;
        exp_ph = fwd ? {exp_ph[1:0], exp_ph[2]} : {exp_ph[0], exp_ph[2:1]};
        exp_sp = ~exp_sp;
        chk_word({13'h0000, phase_sel}, {13'h0000, exp_ph});
        chk_bit(speed_pulse, exp_sp);
      end
    end
    c.dir_ovr_en = 1'b0;
    host.put_cfg(c);
    step;
    exp_sp = ~exp_sp;
    $display("test direction done");

    // coast with a step in it, then restart
    host.put_pins(4'h6);
    cyc(4);
    chk_bit(gates_off, 1'b1);
    step;
    chk_word({13'h0000, phase_sel}, {13'h0000, PHASE_B});
    chk_bit(speed_pulse, exp_sp);
    chk_bit(status.sleep_req, 1'b0);
    chk_bit(status.coasting, 1'b1);
    host.put_pins(4'h4);
    k = 0;
    while (restart_req !== 1'b1 && k < 10) begin
      cyc(1);
      k++;
    end
    chk_bit(restart_req, 1'b1);
    cyc(1);
    chk_bit(restart_req, 1'b0);
    chk_bit(gates_off, 1'b0);
    chk_word({13'h0000, phase_sel}, {13'h0000, PHASE_A});
    $display("test coast done");

    // brake: ramp to threshold, hold, then overrides both ways
    host.put_pins(4'hC);
    cyc(4);
    chk_bit(status.ramping, 1'b1);
    chk_bit(status.braking, 1'b0);
    chk_word(speed_ref, 16'h0400);
    c.brake_speed_threshold = 16'h0300;
    host.put_cfg(c);
    cyc(2);
    chk_word(speed_ref, 16'h0300);
    mspeed = 16'h0300;
    cyc(3);
    chk_bit(status.braking, 1'b1);
    chk_word(speed_ref, 16'h0000);
    cyc(20);
    chk_bit(status.braking, 1'b1);
    c.brake_ovr_en = 1'b1;
    c.brake_ovr_val = 1'b0;
    host.put_cfg(c);
    cyc(3);
    chk_bit(status.braking, 1'b0);
    host.put_pins(4'h4);
    c.brake_ovr_val = 1'b1;
    host.put_cfg(c);
    cyc(4);
    chk_bit(status.braking, 1'b1);
    c.brake_ovr_en = 1'b0;
    host.put_cfg(c);
    cyc(3);
    chk_bit(status.braking, 1'b0);
    $display("test brake done");

    // reference sources and sleep request
    c.i2c_speed_cmd = 16'h0000;
    host.put_cfg(c);
    cyc(2);
    chk_bit(status.sleep_req, 1'b1);
    c.speed_mode = MODE_ANALOG;
    host.put_cfg(c);
    cyc(2);
    chk_word(speed_ref, 16'h0123);
    analog = 16'h0456;
    cyc(2);
    chk_word(speed_ref, 16'h0456);
    chk_bit(status.sleep_req, 1'b0);
    c.speed_mode = MODE_PWM;
    c.glitch_cycles = 8'h04;
    host.put_pins(4'h5);
    host.put_cfg(c);
    cyc(2100);
    chk_word(speed_ref, 16'h0400);
    // three-cycle spikes, shorter than the filter setting, must not count as duty
    repeat (140) begin
      host.put_pins(4'h5);
      cyc(2);
      host.put_pins(4'h4);
      cyc(14);
    end
    chk_word(speed_ref, 16'h0000);
    chk_bit(status.sleep_req, 1'b1);
    c.speed_mode = MODE_FREQ;
    host.put_cfg(c);
    cyc(2100);
    chk_word(speed_ref, 16'h0000);
    // square wave of 8 cycles gives 128 rising edges in each 1024-cycle window
    repeat (300) begin
      host.put_pins(4'h5);
      cyc(3);
      host.put_pins(4'h4);
      cyc(3);
    end
    chk_word(speed_ref, 16'h0080);
    chk_bit(status.sleep_req, 1'b0);
    $display("test speed modes done");

    // stored pull-up choice only lands on the next reset
    c.pullup_nv = 1'b0;
    host.put_cfg(c);
    cyc(2);
    chk_bit(pullup_active, 1'b1);
    do_reset;
    chk_bit(pullup_active, 1'b0);
    $display("test pull-up done");
    close_out;
  end
endmodule
